/* File: ec_pkg.sv */
// Constants, register layouts and helper functions for the echo canceller mode control.
// What this block does
// RQ1 - With the DC tap bit set, the last data tap of the linear canceller carries a constant +1.
// RQ2 - With the DC tap bit clear, the last data tap carries the oldest transmit sample like any other tap.
// RQ3 - Linear canceller coefficients adapt only while the adaptation enable bit is set.
// RQ4 - With adaptation off, the coefficients keep their current values.
// RQ5 - While the coefficient clear bit is set, every coefficient is forced to zero on every cycle.
// RQ6 - The output suppress bit forces the echo replica to zero before it is subtracted.
// RQ7 - Output suppression does not stop coefficient adaptation.
// RQ8 - The two-bit linear step code selects a normalized gain of 1, 4, 64 or 512.
// RQ9 - The invert bit negates the receive path in two's complement at the nonlinear canceller output.
// RQ10 - The invert bit acts independently of all other nonlinear canceller settings.
// RQ11 - The nonlinear canceller has its own adapt, clear and suppress bits acting as in the linear one.
// RQ12 - The three-bit delay field delays the nonlinear canceller's transmit symbol input by that many symbols.
// RQ13 - The nonlinear gain bit makes the adaptation step eight times larger when set.
package ec_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] EC_LIN_CTRL_ADDR = 8'h08;
    localparam logic [7:0] EC_NL_CTRL_ADDR = 8'h09;
    localparam logic [7:0] EC_LIN_CTRL_RESET = 8'h00;
    localparam logic [7:0] EC_NL_CTRL_RESET = 8'h00;
    localparam logic [7:0] EC_LIN_CTRL_MASK = 8'h3F;
    localparam logic [7:0] EC_UNMAPPED_DATA = 8'h00;

    // ****************************************
    // Arithmetic constants
    // ****************************************
    localparam int EC_FRAC_BITS = 8;
    localparam logic signed [2:0] EC_DC_TAP_LEVEL = 3'sd1;
    localparam logic [3:0] EC_LIN_SHIFT_G1 = 4'd0;
    localparam logic [3:0] EC_LIN_SHIFT_G4 = 4'd2;
    localparam logic [3:0] EC_LIN_SHIFT_G64 = 4'd6;
    localparam logic [3:0] EC_LIN_SHIFT_G512 = 4'd9;
    localparam logic [3:0] EC_NL_SHIFT_LOW = 4'd0;
    localparam logic [3:0] EC_NL_SHIFT_HIGH = 4'd3;
    localparam int EC_NL_MAX_DELAY = 7;

    // Bit 7 down to bit 0 of the linear control register.
    typedef struct packed {
        logic [1:0] unused;
        logic dc_offset_tap_force;
        logic adapt;
        logic zero_coef;
        logic zero_out;
        logic [1:0] gain;
    } ec_lin_ctrl_s;

    // Bit 7 down to bit 0 of the nonlinear control register.
    typedef struct packed {
        logic negate;
        logic [2:0] delay;
        logic adapt;
        logic zero_coef;
        logic zero_out;
        logic gain;
    } ec_nl_ctrl_s;

    // Quat code is sign then magnitude: sign 1 is positive, magnitude 0 is the outer level.
    function automatic logic signed [2:0] ec_quat_level(input logic [1:0] code);
        case (code)
            2'b00: ec_quat_level = -3'sd3;
            2'b01: ec_quat_level = -3'sd1;
            2'b10: ec_quat_level = 3'sd3;
            default: ec_quat_level = 3'sd1;
        endcase
    endfunction : ec_quat_level

    function automatic logic [3:0] ec_lin_shift(input logic [1:0] gain);
        case (gain)
            2'b00: ec_lin_shift = EC_LIN_SHIFT_G1;
            2'b01: ec_lin_shift = EC_LIN_SHIFT_G4;
            2'b10: ec_lin_shift = EC_LIN_SHIFT_G64;
            default: ec_lin_shift = EC_LIN_SHIFT_G512;
        endcase
    endfunction : ec_lin_shift

endpackage : ec_pkg

/* File: ec_lin_canceller.sv */
// Linear echo canceller: transmit delay line, replica sum and sign-error coefficient update.
`timescale 1ns/1ns
module ec_lin_canceller #(
    parameter int TAPS = 8,
    parameter int CW = 24,
    parameter int RW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control and data
    input ec_pkg::ec_lin_ctrl_s ctrl,
    input wire logic signed [2:0] tx_level,
    input wire logic signed [RW-1:0] err,
    // Results
    output logic signed [RW-1:0] replica,
    output logic signed [2:0] last_tap,
    output logic [TAPS-1:0][CW-1:0] coefs
);
    import ec_pkg::*;

    logic signed [2:0] dline [TAPS-1];
    logic signed [2:0] tap [TAPS];
    logic signed [CW+3:0] acc;

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < TAPS - 1; i++) dline[i] <= '0;
        end else begin
            dline[0] <= tx_level;
            for (int i = 1; i < TAPS - 1; i++) dline[i] <= dline[i-1];
        end
    end

    always_comb begin
        tap[0] = tx_level;
        for (int i = 1; i < TAPS - 1; i++) tap[i] = dline[i-1];
        // RQ1 RQ2 last tap select
        tap[TAPS-1] = ctrl.dc_offset_tap_force ? EC_DC_TAP_LEVEL : dline[TAPS-2];
    end
    assign last_tap = tap[TAPS-1];

    always_comb begin
        acc = '0;
        for (int i = 0; i < TAPS; i++) begin
            acc = acc + (CW+4)'(signed'(coefs[i])) * (CW+4)'(tap[i]);
        end
        replica = RW'(acc >>> EC_FRAC_BITS);
    end

    // Sign-error update keeps the adder narrow; the step is the tap level scaled by the gain.
    always_ff @(posedge clk) begin
        // RQ5 RQ3 RQ4 clear adapt hold
        if (rst || ctrl.zero_coef) begin
            coefs <= '0;
        end else if (ctrl.adapt) begin
            for (int i = 0; i < TAPS; i++) begin
                // RQ8 gain step select
                if (err < 0) coefs[i] <= coefs[i] - (CW'(tap[i]) << ec_lin_shift(ctrl.gain));
                else coefs[i] <= coefs[i] + (CW'(tap[i]) << ec_lin_shift(ctrl.gain));
            end
        end
    end

endmodule : ec_lin_canceller

/* File: ec_nl_canceller.sv */
// Nonlinear echo canceller: delayed symbol pair addresses a table of adaptive replica entries.
`timescale 1ns/1ns
module ec_nl_canceller #(
    parameter int CW = 24,
    parameter int RW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control and data
    input ec_pkg::ec_nl_ctrl_s ctrl,
    input wire logic [1:0] tx_quat,
    input wire logic signed [RW-1:0] err,
    // Results
    output logic signed [RW-1:0] replica,
    output logic [1:0] sym,
    output logic [15:0][CW-1:0] coefs
);
    import ec_pkg::*;

    logic [1:0] dline [EC_NL_MAX_DELAY];
    logic [1:0] prev_sym;
    logic [3:0] idx;

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < EC_NL_MAX_DELAY; i++) dline[i] <= '0;
            prev_sym <= '0;
        end else begin
            dline[0] <= tx_quat;
            for (int i = 1; i < EC_NL_MAX_DELAY; i++) dline[i] <= dline[i-1];
            prev_sym <= sym;
        end
    end

    // RQ12 symbol delay select
    assign sym = (ctrl.delay == 3'd0) ? tx_quat : dline[ctrl.delay - 3'd1];
    assign idx = {sym, prev_sym};
    assign replica = RW'(signed'(coefs[idx]) >>> EC_FRAC_BITS);

    always_ff @(posedge clk) begin
        // RQ11 own clear and freeze
        if (rst || ctrl.zero_coef) begin
            coefs <= '0;
        end else if (ctrl.adapt) begin
            // RQ13 eight times step
            if (err < 0) coefs[idx] <= coefs[idx] - (CW'(1) << (ctrl.gain ? EC_NL_SHIFT_HIGH : EC_NL_SHIFT_LOW));
            else coefs[idx] <= coefs[idx] + (CW'(1) << (ctrl.gain ? EC_NL_SHIFT_HIGH : EC_NL_SHIFT_LOW));
        end
    end

endmodule : ec_nl_canceller

/* File: ec_mode_ctrl.sv */
// Top of the echo canceller mode control: register port, both cancellers and the receive path.
`timescale 1ns/1ns
module ec_mode_ctrl #(
    parameter int LIN_TAPS = 8,
    parameter int CW = 24,
    parameter int RW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Microprocessor register port
    input wire logic up_cs,
    input wire logic up_wr,
    input wire logic up_rd,
    input wire logic [7:0] up_addr,
    input wire logic [7:0] up_wdata,
    output logic [7:0] up_rdata,
    // Transmit symbols and receive samples
    input wire logic [1:0] tx_quat,
    input wire logic signed [RW-1:0] rx_in,
    output logic signed [RW-1:0] rx_out
);
    import ec_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (LIN_TAPS < 2) begin : g_bad_taps
        $error("LIN_TAPS must be at least 2");
    end
    if (CW < RW + EC_FRAC_BITS || RW < 4) begin : g_bad_width
        $error("Coefficient width too small for the receive width");
    end

    // ****************************************
    // Control registers
    // ****************************************
    ec_lin_ctrl_s lin_ctrl;
    ec_nl_ctrl_s nl_ctrl;
    logic lin_sel;
    logic nl_sel;

    assign lin_sel = up_cs && (up_addr == EC_LIN_CTRL_ADDR);
    assign nl_sel = up_cs && (up_addr == EC_NL_CTRL_ADDR);

    // Bits 7 and 6 of the linear register have no function and stay zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            lin_ctrl <= EC_LIN_CTRL_RESET;
        end else if (lin_sel && up_wr) begin
            lin_ctrl <= up_wdata & EC_LIN_CTRL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            nl_ctrl <= EC_NL_CTRL_RESET;
        end else if (nl_sel && up_wr) begin
            nl_ctrl <= up_wdata;
        end
    end

    // Read data is registered; it holds between reads so a slow host may sample it late.
    always_ff @(posedge clk) begin
        if (rst) begin
            up_rdata <= EC_UNMAPPED_DATA;
        end else if (up_cs && up_rd) begin
            if (lin_sel) up_rdata <= lin_ctrl;
            else if (nl_sel) up_rdata <= nl_ctrl;
            else up_rdata <= EC_UNMAPPED_DATA;
        end
    end

    // ****************************************
    // Cancellers
    // ****************************************
    logic signed [2:0] tx_level;
    logic signed [RW-1:0] lin_rep;
    logic signed [RW-1:0] nl_rep;
    logic signed [2:0] lin_last_tap;
    logic [1:0] nl_sym;
    logic [LIN_TAPS-1:0][CW-1:0] lin_coefs;
    logic [15:0][CW-1:0] nl_coefs;
    logic signed [RW-1:0] lin_diff;
    logic signed [RW-1:0] nl_diff;

    assign tx_level = ec_quat_level(tx_quat);

    ec_lin_canceller #(
        .TAPS(LIN_TAPS),
        .CW(CW),
        .RW(RW)
    ) u_lin (
        .clk(clk),
        .rst(rst),
        .ctrl(lin_ctrl),
        .tx_level(tx_level),
        .err(nl_diff),
        .replica(lin_rep),
        .last_tap(lin_last_tap),
        .coefs(lin_coefs)
    );

    ec_nl_canceller #(
        .CW(CW),
        .RW(RW)
    ) u_nl (
        .clk(clk),
        .rst(rst),
        .ctrl(nl_ctrl),
        .tx_quat(tx_quat),
        .err(nl_diff),
        .replica(nl_rep),
        .sym(nl_sym),
        .coefs(nl_coefs)
    );

    // ****************************************
    // Receive path
    // ****************************************
    // Both cancellers adapt on the final residual, so suppressing one replica still trains it.
    always_comb begin
        // RQ6 RQ7 replica suppress
        lin_diff = rx_in - (lin_ctrl.zero_out ? RW'(0) : lin_rep);
        // RQ11 nonlinear suppress
        nl_diff = lin_diff - (nl_ctrl.zero_out ? RW'(0) : nl_rep);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_out <= '0;
        end else begin
            // RQ9 RQ10 path invert
            rx_out <= nl_ctrl.negate ? -nl_diff : nl_diff;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    function automatic logic [CW-1:0] mag(input logic [CW-1:0] v);
        mag = v[CW-1] ? -v : v;
    endfunction : mag

    a_dc_tap_force: // RQ1
        assert property (@(posedge clk) disable iff (rst)
            lin_ctrl.dc_offset_tap_force |-> lin_last_tap == EC_DC_TAP_LEVEL)
        else $error("last tap is not +1 while the DC tap is forced");

    a_dc_tap_normal: // RQ2
        assert property (@(posedge clk) disable iff (rst)
            (!lin_ctrl.dc_offset_tap_force && !$past(rst, LIN_TAPS))
            |-> lin_last_tap == $past(tx_level, LIN_TAPS - 1))
        else $error("last tap does not carry the oldest transmit sample");

    a_lin_adapt_on: // RQ3
        assert property (@(posedge clk) disable iff (rst)
            (lin_ctrl.adapt && !lin_ctrl.zero_coef) |=> lin_coefs != $past(lin_coefs))
        else $error("linear coefficients did not move while adapting");

    a_lin_freeze: // RQ4
        assert property (@(posedge clk) disable iff (rst)
            (!lin_ctrl.adapt && !lin_ctrl.zero_coef) |=> lin_coefs == $past(lin_coefs))
        else $error("linear coefficients changed while frozen");

    a_lin_clear: // RQ5
        assert property (@(posedge clk) disable iff (rst)
            lin_ctrl.zero_coef[*2] |-> lin_coefs == '0)
        else $error("linear coefficients not zero while clearing");

    a_both_suppress: // RQ6
        assert property (@(posedge clk) disable iff (rst)
            (lin_ctrl.zero_out && nl_ctrl.zero_out && !nl_ctrl.negate) |=> rx_out == $past(rx_in))
        else $error("replica not suppressed");

    a_suppress_adapts: // RQ7
        assert property (@(posedge clk) disable iff (rst)
            (lin_ctrl.zero_out && lin_ctrl.adapt && !lin_ctrl.zero_coef)
            |=> lin_coefs[0] != $past(lin_coefs[0]))
        else $error("suppression stopped linear adaptation");

    a_lin_step_size: // RQ8
        assert property (@(posedge clk) disable iff (rst)
            (lin_ctrl.adapt && !lin_ctrl.zero_coef)
            |=> mag(lin_coefs[0] - $past(lin_coefs[0]))
                == (mag(CW'($past(tx_level))) << ec_lin_shift($past(lin_ctrl.gain))))
        else $error("linear step does not match the gain code");

    a_path_negate: // RQ9
        assert property (@(posedge clk) disable iff (rst)
            nl_ctrl.negate |=> rx_out == RW'(-$past(nl_diff)))
        else $error("receive path not negated");

    a_negate_indep: // RQ10
        assert property (@(posedge clk) disable iff (rst)
            (nl_ctrl.negate && nl_ctrl.zero_out && lin_ctrl.zero_out) |=> rx_out == RW'(-$past(rx_in)))
        else $error("negation affected by other settings");

    a_nl_clear_hold: // RQ11
        assert property (@(posedge clk) disable iff (rst)
            (nl_ctrl.zero_coef |=> nl_coefs == '0)
            and ((!nl_ctrl.adapt && !nl_ctrl.zero_coef) |=> nl_coefs == $past(nl_coefs)))
        else $error("nonlinear clear or freeze misbehaved");

    a_sym_delay: // RQ12
        assert property (@(posedge clk) disable iff (rst)
            (nl_ctrl.delay == 3'd2 && $stable(nl_ctrl) && !$past(rst, 2)) |-> nl_sym == $past(tx_quat, 2))
        else $error("nonlinear symbol delay wrong");

    a_nl_step_size: // RQ13
        assert property (@(posedge clk) disable iff (rst)
            (nl_ctrl.adapt && !nl_ctrl.zero_coef)
            |=> mag(nl_coefs[$past({nl_sym, u_nl.prev_sym})] - $past(nl_coefs[{nl_sym, u_nl.prev_sym}]))
                == (CW'(1) << ($past(nl_ctrl.gain) ? EC_NL_SHIFT_HIGH : EC_NL_SHIFT_LOW)))
        else $error("nonlinear step does not match the gain bit");

    // ****************************************
    // Register port, receive path and canceller checks
    // ****************************************
    // A write must land whole on the next cycle, or a mode change would be seen half applied.
    a_lin_write_lands: // RQ1
        assert property (@(posedge clk) disable iff (rst)
            (lin_sel && up_wr) |=> lin_ctrl == ($past(up_wdata) & EC_LIN_CTRL_MASK))
        else $error("linear control write did not land");

    a_nl_write_lands: // RQ12
        assert property (@(posedge clk) disable iff (rst)
            (nl_sel && up_wr) |=> nl_ctrl == $past(up_wdata))
        else $error("nonlinear control write did not land");

    a_lin_reg_hold: // RQ3
        assert property (@(posedge clk) disable iff (rst)
            !(lin_sel && up_wr) |=> $stable(lin_ctrl))
        else $error("linear control changed without a write");

    a_nl_reg_hold: // RQ11
        assert property (@(posedge clk) disable iff (rst)
            !(nl_sel && up_wr) |=> $stable(nl_ctrl))
        else $error("nonlinear control changed without a write");

    a_lin_read_data: // RQ8
        assert property (@(posedge clk) disable iff (rst)
            (lin_sel && up_rd) |=> up_rdata == $past(lin_ctrl))
        else $error("linear control read back wrong");

    a_nl_read_data: // RQ13
        assert property (@(posedge clk) disable iff (rst)
            (nl_sel && up_rd) |=> up_rdata == $past(nl_ctrl))
        else $error("nonlinear control read back wrong");

    a_unmapped_read: // RQ3
        assert property (@(posedge clk) disable iff (rst)
            (up_cs && up_rd && !lin_sel && !nl_sel) |=> up_rdata == EC_UNMAPPED_DATA)
        else $error("unmapped read did not return zero");

    a_rdata_hold: // RQ3
        assert property (@(posedge clk) disable iff (rst)
            !(up_cs && up_rd) |=> $stable(up_rdata))
        else $error("read data changed without a read");

    a_lin_spare_zero: // RQ1
        assert property (@(posedge clk) disable iff (rst)
            lin_ctrl.unused == 2'b00)
        else $error("spare linear control bits not zero");

    a_normal_path: // RQ6
        assert property (@(posedge clk) disable iff (rst)
            (!lin_ctrl.zero_out && !nl_ctrl.zero_out && !nl_ctrl.negate)
            |=> rx_out == $past(rx_in - lin_rep - nl_rep))
        else $error("receive path did not subtract both replicas");

    a_lin_only_suppress: // RQ6
        assert property (@(posedge clk) disable iff (rst)
            (lin_ctrl.zero_out && !nl_ctrl.zero_out && !nl_ctrl.negate)
            |=> rx_out == $past(rx_in - nl_rep))
        else $error("linear suppression did not remove only the linear replica");

    a_lin_rep_cleared: // RQ5
        assert property (@(posedge clk) disable iff (rst)
            lin_ctrl.zero_coef[*2] |-> lin_rep == '0)
        else $error("linear replica not zero while clearing");

    a_nl_adapt_moves: // RQ11
        assert property (@(posedge clk) disable iff (rst)
            (nl_ctrl.adapt && !nl_ctrl.zero_coef) |=> nl_coefs != $past(nl_coefs))
        else $error("nonlinear coefficients did not move while adapting");

    a_nl_sym_direct: // RQ12
        assert property (@(posedge clk) disable iff (rst)
            nl_ctrl.delay == 3'd0 |-> nl_sym == tx_quat)
        else $error("nonlinear symbol delayed with a zero delay field");

endmodule : ec_mode_ctrl

/* File: ec_mode_ctrl_tb_top.sv */
// Self-checking testbench for the echo canceller mode control.
`timescale 1ns/1ns
module ec_mode_ctrl_tb_top;
    import ec_pkg::*;

    // ****************************************
    // Stimulus and observation signals
    // ****************************************
    localparam logic [15:0] RX_LEVEL = 16'h3E80;
    localparam logic [7:0] UNMAPPED_ADDR = 8'h0A;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic up_cs = 1'b0;
    logic up_wr = 1'b0;
    logic up_rd = 1'b0;
    logic [7:0] up_addr = 8'h00;
    logic [7:0] up_wdata = 8'h00;
    logic [7:0] up_rdata;
    logic [1:0] tx_quat = 2'b11;
    logic signed [15:0] rx_in = RX_LEVEL;
    logic signed [15:0] rx_out;
    logic [15:0] held;
    int mismatches = 0;
    int n_tests = 0;
    int lat0;
    int lat5;

    ec_mode_ctrl ec_mode_ctrl_inst (
        .clk(clk),
        .rst(rst),
        .up_cs(up_cs),
        .up_wr(up_wr),
        .up_rd(up_rd),
        .up_addr(up_addr),
        .up_wdata(up_wdata),
        .up_rdata(up_rdata),
        .tx_quat(tx_quat),
        .rx_in(rx_in),
        .rx_out(rx_out)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : cycles

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        up_cs = 1'b1;
        up_wr = 1'b1;
        up_addr = addr;
        up_wdata = data;
        @(negedge clk);
        up_cs = 1'b0;
        up_wr = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk);
        up_cs = 1'b1;
        up_rd = 1'b1;
        up_addr = addr;
        @(negedge clk);
        up_cs = 1'b0;
        up_rd = 1'b0;
        chk({8'h00, up_rdata}, {8'h00, exp});
    endtask : reg_rd

    // Replica growth over exactly 256 cycles is independent of pipeline latency,
    // because the coefficient sum rises by a whole multiple of the fraction scale.
    task automatic grow(input logic [7:0] lin, input logic [7:0] nl, input logic [1:0] quat, input logic [15:0] exp);
        logic [15:0] first;
        tx_quat = quat;
        reg_wr(EC_LIN_CTRL_ADDR, lin | 8'h08);
        reg_wr(EC_NL_CTRL_ADDR, nl | 8'h04);
        cycles(12);
        reg_wr(EC_LIN_CTRL_ADDR, lin);
        reg_wr(EC_NL_CTRL_ADDR, nl);
        cycles(4);
        first = rx_out;
        cycles(256);
        chk(first - rx_out, exp);
    endtask : grow

    task automatic pass_chk(input logic [7:0] nl, input logic neg);
        logic [15:0] vals [4];
        vals = '{16'h1234, 16'hFEDC, 16'h0001, 16'h7FFF};
        reg_wr(EC_NL_CTRL_ADDR, nl);
        for (int i = 0; i < 4; i++) begin
            rx_in = vals[i];
            @(negedge clk);
            chk(rx_out, neg ? 16'h0000 - vals[i] : vals[i]);
        end
        rx_in = RX_LEVEL;
    endtask : pass_chk

    // Cycles from a symbol change until the untrained table entry is addressed.
    task automatic nl_lat(input logic [2:0] dly, output int n);
        reg_wr(EC_NL_CTRL_ADDR, {1'b0, dly, 4'h0});
        tx_quat = 2'b11;
        cycles(12);
        tx_quat = 2'b00;
        n = 0;
        while (rx_out !== RX_LEVEL && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask : nl_lat

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        cycles(8);
        rst = 1'b0;
        reg_rd(EC_LIN_CTRL_ADDR, EC_LIN_CTRL_RESET);
        reg_rd(EC_NL_CTRL_ADDR, EC_NL_CTRL_RESET);
        reg_wr(UNMAPPED_ADDR, 8'hFF);
        reg_rd(UNMAPPED_ADDR, 8'h00);
        reg_rd(EC_LIN_CTRL_ADDR, 8'h00);
        reg_wr(EC_LIN_CTRL_ADDR, 8'hFF);
        reg_rd(EC_LIN_CTRL_ADDR, 8'h3F);
        reg_wr(EC_NL_CTRL_ADDR, 8'hA5);
        reg_rd(EC_NL_CTRL_ADDR, 8'hA5);
        // Linear gain codes with every tap at +1.
        grow(8'h10, 8'h02, 2'b11, 16'h0008);
        grow(8'h11, 8'h02, 2'b11, 16'h0020);
        grow(8'h12, 8'h02, 2'b11, 16'h0200);
        grow(8'h13, 8'h02, 2'b11, 16'h1000);
        // Symbols at -3: the forced tap adds 1 instead of 9 to the tap energy.
        grow(8'h30, 8'h02, 2'b00, 16'h0040);
        grow(8'h10, 8'h02, 2'b00, 16'h0048);
        grow(8'h04, 8'h08, 2'b11, 16'h0001);
        grow(8'h04, 8'h09, 2'b11, 16'h0008);
        nl_lat(3'd0, lat0);
        nl_lat(3'd5, lat5);
        chk(16'(lat5 - lat0), 16'h0005);
        // Train while suppressed, then freeze and look at the kept replica.
        reg_wr(EC_NL_CTRL_ADDR, 8'h02);
        tx_quat = 2'b11;
        reg_wr(EC_LIN_CTRL_ADDR, 8'h0F);
        cycles(12);
        reg_wr(EC_LIN_CTRL_ADDR, 8'h17);
        cycles(100);
        reg_wr(EC_LIN_CTRL_ADDR, 8'h00);
        cycles(4);
        held = rx_out;
        chk({15'h0000, held < 16'h3A80}, 16'h0001);
        cycles(50);
        chk(rx_out, held);
        reg_wr(EC_LIN_CTRL_ADDR, 8'h08);
        cycles(3);
        chk(rx_out, RX_LEVEL);
        reg_wr(EC_LIN_CTRL_ADDR, 8'h1B);
        cycles(20);
        chk(rx_out, RX_LEVEL);
        reg_wr(EC_LIN_CTRL_ADDR, 8'h04);
        pass_chk(8'h02, 1'b0);
        pass_chk(8'h82, 1'b1);
        pass_chk(8'h8E, 1'b1);
        pass_chk(8'hF3, 1'b1);
        pass_chk(8'h72, 1'b0);
        finish_test();
    end
endmodule : ec_mode_ctrl_tb_top
